// ==== inc/deb_pkg.sv ====
package deb_pkg;
    // register offsets on the serial register port
    localparam logic [7:0] SERIAL_DIAG_ENABLE_OFS    = 8'h28;
    localparam logic [7:0] CONVERTER_DIAG_ENABLE_OFS = 8'h29;
    localparam logic [7:0] DIGITAL_DIAG_ENABLE_OFS   = 8'h2A;
    localparam logic [7:0] CONVERSION_RESULT_OFS     = 8'h2C;
    localparam logic [7:0] MAIN_ERROR_FLAGS_OFS      = 8'h2D;
    localparam logic [7:0] SERIAL_ERROR_FLAGS_OFS    = 8'h2E;
    localparam logic [7:0] CONVERTER_ERROR_FLAGS_OFS = 8'h2F;

    // reset values
    localparam logic [7:0]  SERIAL_DIAG_ENABLE_RST    = 8'h10;
    localparam logic [7:0]  CONVERTER_DIAG_ENABLE_RST = 8'h07;
    localparam logic [7:0]  DIGITAL_DIAG_ENABLE_RST   = 8'h0D;
    localparam logic [23:0] CONVERSION_RESULT_RST     = 24'h000000;
    localparam logic [7:0]  FLAGS_RST                 = 8'h00;

    // writable bits of each enable register
    localparam logic [7:0] SERIAL_DIAG_ENABLE_MASK    = 8'h1E;
    localparam logic [7:0] CONVERTER_DIAG_ENABLE_MASK = 8'h3F;
    localparam logic [7:0] DIGITAL_DIAG_ENABLE_MASK   = 8'h1F;

    // serial enable / error fields
    localparam int SER_IGNORE_BIT = 4;
    localparam int SER_SCLK_BIT   = 3;
    localparam int SER_READ_BIT   = 2;
    localparam int SER_WRITE_BIT  = 1;
    localparam int SER_CRC_BIT    = 0;
    localparam logic [7:0] SERIAL_W1C_MASK = 8'h17;

    // converter enable / error fields
    localparam int CNV_DREG_BIT  = 5;
    localparam int CNV_AREG_BIT  = 4;
    localparam int CNV_REF_BIT   = 3;
    localparam int CNV_SAT_BIT   = 2;
    localparam int CNV_UNSET_BIT = 1;
    localparam int CNV_CLK_BIT   = 0;

    // digital enable fields
    localparam int DIG_REGMAP_BIT = 4;
    localparam int DIG_RAM_BIT    = 3;
    localparam int DIG_FUSE_BIT   = 2;
    localparam int DIG_MCLK_BIT   = 0;

    // main error flags fields
    localparam int MAIN_ANY_BIT   = 7;
    localparam int MAIN_CNV_BIT   = 6;
    localparam int MAIN_DIG_BIT   = 5;
    localparam int MAIN_CLK_BIT   = 4;
    localparam int MAIN_SAT_BIT   = 3;
    localparam int MAIN_UNSET_BIT = 2;
    localparam int MAIN_SER_BIT   = 1;
    localparam int MAIN_POR_BIT   = 0;
endpackage : deb_pkg

// ==== rtl/deb_bank.sv ====
`timescale 1ns/10ps

module deb_bank (
    // clock, reset, enable
    input  wire logic        i_core_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_ce,
    // register port from the serial decoder
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic        i_reg_wr,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_reg_rd,
    output logic      [23:0] o_reg_rdata,
    // serial interface error events
    input  wire logic        i_ser_ignore_evt,
    input  wire logic        i_sclk_count_evt,
    input  wire logic        i_cs_framed,
    input  wire logic        i_ser_read_evt,
    input  wire logic        i_ser_write_evt,
    input  wire logic        i_ser_crc_evt,
    // converter path error events
    input  wire logic        i_digital_regulator_evt,
    input  wire logic        i_analog_regulator_evt,
    input  wire logic        i_reference_evt,
    input  wire logic        i_filter_saturated_evt,
    input  wire logic        i_filter_unsettled_evt,
    input  wire logic        i_no_clock_evt,
    // digital integrity error events
    input  wire logic        i_regmap_crc_evt,
    input  wire logic        i_ram_crc_evt,
    input  wire logic        i_fuse_crc_evt,
    // power-on flag and conversion data
    input  wire logic        i_por_flag,
    input  wire logic        i_result_valid,
    input  wire logic [23:0] i_result_data,
    // enables steering the checkers, and the main error summary
    output logic             o_regmap_crc_en,
    output logic             o_ram_crc_en,
    output logic             o_fuse_crc_en,
    output logic             o_master_clock_counter_en,
    output logic             o_ext_clock_check_en,
    output logic             o_digital_regulator_mon_en,
    output logic             o_analog_regulator_mon_en,
    output logic             o_reference_detect_en,
    output logic             o_main_error
);
    logic [7:0]  serial_diag_enable_r;
    logic [7:0]  converter_diag_enable_r;
    logic [7:0]  digital_diag_enable_r;
    logic [23:0] conversion_result_r;
    logic [7:0]  serial_error_flags_r;
    logic [7:0]  converter_error_flags_r;
    logic [2:0]  digital_error_r;
    logic [7:0]  main_error_flags;
    logic [7:0]  serial_set;
    logic [7:0]  converter_set;
    logic [2:0]  digital_set;
    logic [7:0]  w1c;
    logic        digital_error_any;

    function automatic logic hit(input logic [7:0] ofs);
        hit = i_ce && i_reg_wr && (i_reg_addr == ofs);
    endfunction : hit

    // serial enable register; reserved bits masked so they always read zero
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            serial_diag_enable_r <= deb_pkg::SERIAL_DIAG_ENABLE_RST;
        end else if (hit(deb_pkg::SERIAL_DIAG_ENABLE_OFS)) begin
            serial_diag_enable_r <= i_reg_wdata & deb_pkg::SERIAL_DIAG_ENABLE_MASK;
        end
    end

    // converter enable register
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            converter_diag_enable_r <= deb_pkg::CONVERTER_DIAG_ENABLE_RST;
        end else if (hit(deb_pkg::CONVERTER_DIAG_ENABLE_OFS)) begin
            converter_diag_enable_r <= i_reg_wdata & deb_pkg::CONVERTER_DIAG_ENABLE_MASK;
        end
    end

    // digital enable register; reserved bit1 kept writable
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            digital_diag_enable_r <= deb_pkg::DIGITAL_DIAG_ENABLE_RST;
        end else if (hit(deb_pkg::DIGITAL_DIAG_ENABLE_OFS)) begin
            digital_diag_enable_r <= i_reg_wdata & deb_pkg::DIGITAL_DIAG_ENABLE_MASK;
        end
    end

    // conversion result, read-only to software
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            conversion_result_r <= deb_pkg::CONVERSION_RESULT_RST;
        end else if (i_ce && i_result_valid) begin
            conversion_result_r <= i_result_data;
        end
    end

    // gated event sets
    always_comb begin
        serial_set = 8'h00;
        serial_set[deb_pkg::SER_IGNORE_BIT] = i_ser_ignore_evt && serial_diag_enable_r[deb_pkg::SER_IGNORE_BIT];
        serial_set[deb_pkg::SER_SCLK_BIT]   = i_sclk_count_evt && i_cs_framed
                                              && serial_diag_enable_r[deb_pkg::SER_SCLK_BIT];
        serial_set[deb_pkg::SER_READ_BIT]   = i_ser_read_evt && serial_diag_enable_r[deb_pkg::SER_READ_BIT];
        serial_set[deb_pkg::SER_WRITE_BIT]  = i_ser_write_evt && serial_diag_enable_r[deb_pkg::SER_WRITE_BIT];
        // crc flag has no enable bit of its own
        serial_set[deb_pkg::SER_CRC_BIT]    = i_ser_crc_evt;
        converter_set = 8'h00;
        converter_set[deb_pkg::CNV_DREG_BIT]  = i_digital_regulator_evt && converter_diag_enable_r[deb_pkg::CNV_DREG_BIT];
        converter_set[deb_pkg::CNV_AREG_BIT]  = i_analog_regulator_evt && converter_diag_enable_r[deb_pkg::CNV_AREG_BIT];
        converter_set[deb_pkg::CNV_REF_BIT]   = i_reference_evt && converter_diag_enable_r[deb_pkg::CNV_REF_BIT];
        converter_set[deb_pkg::CNV_SAT_BIT]   = i_filter_saturated_evt && converter_diag_enable_r[deb_pkg::CNV_SAT_BIT];
        converter_set[deb_pkg::CNV_UNSET_BIT] = i_filter_unsettled_evt
                                                && converter_diag_enable_r[deb_pkg::CNV_UNSET_BIT];
        converter_set[deb_pkg::CNV_CLK_BIT]   = i_no_clock_evt && converter_diag_enable_r[deb_pkg::CNV_CLK_BIT];
        digital_set = {i_regmap_crc_evt && digital_diag_enable_r[deb_pkg::DIG_REGMAP_BIT],
                       i_ram_crc_evt && digital_diag_enable_r[deb_pkg::DIG_RAM_BIT],
                       i_fuse_crc_evt && digital_diag_enable_r[deb_pkg::DIG_FUSE_BIT]};
        // clock-count bit is outside the clear mask, so writes never touch it
        w1c = hit(deb_pkg::SERIAL_ERROR_FLAGS_OFS) ? (i_reg_wdata & deb_pkg::SERIAL_W1C_MASK) : 8'h00;
    end

    // serial error flags: set wins over a same-cycle clear
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            serial_error_flags_r <= deb_pkg::FLAGS_RST;
        end else if (i_ce) begin
            serial_error_flags_r <= (serial_error_flags_r & ~w1c) | serial_set;
        end
    end

    // converter flags are sticky; only reset clears them
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            converter_error_flags_r <= deb_pkg::FLAGS_RST;
        end else if (i_ce) begin
            converter_error_flags_r <= converter_error_flags_r | converter_set;
        end
    end

    // digital flags kept only for the main summary bit
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            digital_error_r <= 3'h0;
        end else if (i_ce) begin
            digital_error_r <= digital_error_r | digital_set;
        end
    end

    assign digital_error_any = |digital_error_r;

    // main flags: the no-clock error goes to bit 4, not into the converter OR
    always_comb begin
        main_error_flags = 8'h00;
        main_error_flags[deb_pkg::MAIN_CNV_BIT]   = |converter_error_flags_r[deb_pkg::CNV_DREG_BIT:deb_pkg::CNV_UNSET_BIT];
        main_error_flags[deb_pkg::MAIN_DIG_BIT]   = digital_error_any;
        main_error_flags[deb_pkg::MAIN_CLK_BIT]   = converter_error_flags_r[deb_pkg::CNV_CLK_BIT];
        main_error_flags[deb_pkg::MAIN_SAT_BIT]   = converter_error_flags_r[deb_pkg::CNV_SAT_BIT];
        main_error_flags[deb_pkg::MAIN_UNSET_BIT] = converter_error_flags_r[deb_pkg::CNV_UNSET_BIT];
        main_error_flags[deb_pkg::MAIN_SER_BIT]   = |serial_error_flags_r;
        main_error_flags[deb_pkg::MAIN_POR_BIT]   = i_por_flag;
        main_error_flags[deb_pkg::MAIN_ANY_BIT]   = |main_error_flags[deb_pkg::MAIN_CNV_BIT:deb_pkg::MAIN_SER_BIT];
    end

    // registered read data; unmapped offsets read zero
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            o_reg_rdata <= 24'h000000;
        end else if (i_ce && i_reg_rd) begin
            case (i_reg_addr)
                deb_pkg::SERIAL_DIAG_ENABLE_OFS:    o_reg_rdata <= {16'h0000, serial_diag_enable_r};
                deb_pkg::CONVERTER_DIAG_ENABLE_OFS: o_reg_rdata <= {16'h0000, converter_diag_enable_r};
                deb_pkg::DIGITAL_DIAG_ENABLE_OFS:   o_reg_rdata <= {16'h0000, digital_diag_enable_r};
                deb_pkg::CONVERSION_RESULT_OFS:     o_reg_rdata <= conversion_result_r;
                deb_pkg::MAIN_ERROR_FLAGS_OFS:      o_reg_rdata <= {16'h0000, main_error_flags};
                deb_pkg::SERIAL_ERROR_FLAGS_OFS:    o_reg_rdata <= {16'h0000, serial_error_flags_r};
                deb_pkg::CONVERTER_ERROR_FLAGS_OFS: o_reg_rdata <= {16'h0000, converter_error_flags_r};
                default:                            o_reg_rdata <= 24'h000000;
            endcase
        end
    end

    assign o_regmap_crc_en            = digital_diag_enable_r[deb_pkg::DIG_REGMAP_BIT];
    assign o_ram_crc_en               = digital_diag_enable_r[deb_pkg::DIG_RAM_BIT];
    assign o_fuse_crc_en              = digital_diag_enable_r[deb_pkg::DIG_FUSE_BIT];
    assign o_master_clock_counter_en  = digital_diag_enable_r[deb_pkg::DIG_MCLK_BIT];
    assign o_ext_clock_check_en       = converter_diag_enable_r[deb_pkg::CNV_CLK_BIT];
    assign o_digital_regulator_mon_en = converter_diag_enable_r[deb_pkg::CNV_DREG_BIT];
    assign o_analog_regulator_mon_en  = converter_diag_enable_r[deb_pkg::CNV_AREG_BIT];
    assign o_reference_detect_en      = converter_diag_enable_r[deb_pkg::CNV_REF_BIT];
    assign o_main_error               = main_error_flags[deb_pkg::MAIN_ANY_BIT];
endmodule : deb_bank

// ==== testbench/deb_checker.sv ====
`timescale 1ns/10ps
module deb_checker (
    // clock, reset and register port
    input wire logic        i_core_clk, i_resetn, i_ce, i_reg_wr, i_reg_rd,
    input wire logic [7:0]  i_reg_addr, i_reg_wdata,
    input wire logic [23:0] o_reg_rdata, i_result_data,
    // events and status
    input wire logic        i_result_valid, i_ser_crc_evt, i_no_clock_evt, o_main_error,
    // enable outputs
    input wire logic        o_regmap_crc_en, o_ram_crc_en, o_fuse_crc_en, o_master_clock_counter_en,
    input wire logic        o_ext_clock_check_en, o_digital_regulator_mon_en, o_analog_regulator_mon_en,
    input wire logic        o_reference_detect_en
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    property p_cnv_wr;
        i_ce && i_reg_wr && i_reg_addr == 8'h29 |=> {o_digital_regulator_mon_en, o_analog_regulator_mon_en,
            o_reference_detect_en, o_ext_clock_check_en} == {$past(i_reg_wdata[5:3]), $past(i_reg_wdata[0])};
    endproperty
    a_cnv_wr: assert property (p_cnv_wr) else $error("converter enable write lost");
    property p_dig_wr;
        i_ce && i_reg_wr && i_reg_addr == 8'h2A |=> {o_regmap_crc_en, o_ram_crc_en, o_fuse_crc_en,
            o_master_clock_counter_en} == {$past(i_reg_wdata[4:2]), $past(i_reg_wdata[0])};
    endproperty
    a_dig_wr: assert property (p_dig_wr) else $error("digital enable write lost");
    property p_rst;
        $rose(i_resetn) |-> !o_regmap_crc_en && o_ram_crc_en && o_fuse_crc_en && o_master_clock_counter_en
            && o_ext_clock_check_en && !o_digital_regulator_mon_en && !o_main_error;
    endproperty
    a_rst: assert property (p_rst) else $error("enable defaults wrong after reset");
    property p_res;
        i_ce && i_result_valid ##1 i_ce && i_reg_rd && i_reg_addr == 8'h2C |=> o_reg_rdata == $past(i_result_data, 2);
    endproperty
    a_res: assert property (p_res) else $error("conversion result read wrong");
    property p_rd8;
        i_ce && i_reg_rd && i_reg_addr == 8'h28 |=> o_reg_rdata[23:5] == 19'h0 && !o_reg_rdata[0];
    endproperty
    a_rd8: assert property (p_rd8) else $error("serial enable reserved bits set");
    property p_crc;
        i_ce && i_ser_crc_evt |=> o_main_error;
    endproperty
    a_crc: assert property (p_crc) else $error("crc error not in main error");
    property p_noclk;
        i_ce && i_no_clock_evt && o_ext_clock_check_en |=> o_main_error;
    endproperty
    a_noclk: assert property (p_noclk) else $error("no-clock error not in main error");
    property p_keep;
        o_main_error && !(i_ce && i_reg_wr && i_reg_addr == 8'h2E) |=> o_main_error;
    endproperty
    a_keep: assert property (p_keep) else $error("main error dropped without clear");
endmodule : deb_checker
bind deb_bank deb_checker u_chk (.*);

// ==== testbench/deb_host_model.sv ====
`timescale 1ns/10ps
module deb_host_model (
    // clock and read data
    input  wire logic        i_core_clk,
    input  wire logic [23:0] i_reg_rdata,
    // register port strobes
    output logic      [7:0]  o_reg_addr,
    output logic      [7:0]  o_reg_wdata,
    output logic             o_reg_wr,
    output logic             o_reg_rd
);
    initial begin
        o_reg_addr = 8'h00;
        o_reg_wdata = 8'h00;
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
    end
    // released lines show the inverse so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        o_reg_addr <= a;
        o_reg_wdata <= d;
        o_reg_wr <= 1'b1;
        @(posedge i_core_clk);
        o_reg_wr <= 1'b0;
        o_reg_addr <= ~a;
        o_reg_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [23:0] q);
        @(posedge i_core_clk);
        o_reg_addr <= a;
        o_reg_rd <= 1'b1;
        @(posedge i_core_clk);
        o_reg_rd <= 1'b0;
        o_reg_addr <= ~a;
        // registered data stands until the next read, take it at the next edge
        @(posedge i_core_clk);
        q = i_reg_rdata;
    endtask : rd
endmodule : deb_host_model

// ==== testbench/deb_bank_test.sv ====
`timescale 1ns/10ps
module deb_bank_test;
    logic clk = 0, rstn = 0, ce = 1, cs = 0, rv = 0, por = 0, wr, rd;
    logic [13:0] ev = 14'h0;
    logic [7:0] a, wd;
    logic [23:0] rdat = 24'h0, rq, v;
    logic [31:0] seed = 32'h00000BDA;
    int failures = 0, cmp_count = 0;
    localparam logic [7:0] OFS [8] = '{8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h2F};
    localparam logic [7:0] RST [8] = '{8'h10, 8'h07, 8'h0D, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    initial forever #5 clk = ~clk;
    deb_host_model host (.i_core_clk(clk), .i_reg_rdata(rq), .o_reg_addr(a), .o_reg_wdata(wd),
        .o_reg_wr(wr), .o_reg_rd(rd));
    deb_bank dut (.i_core_clk(clk), .i_resetn(rstn), .i_ce(ce), .i_reg_addr(a), .i_reg_wr(wr),
        .i_reg_wdata(wd), .i_reg_rd(rd), .o_reg_rdata(rq), .i_ser_ignore_evt(ev[0]), .i_sclk_count_evt(ev[1]),
        .i_cs_framed(cs), .i_ser_read_evt(ev[2]), .i_ser_write_evt(ev[3]), .i_ser_crc_evt(ev[4]),
        .i_digital_regulator_evt(ev[5]), .i_analog_regulator_evt(ev[6]), .i_reference_evt(ev[7]),
        .i_filter_saturated_evt(ev[8]), .i_filter_unsettled_evt(ev[9]), .i_no_clock_evt(ev[10]),
        .i_regmap_crc_evt(ev[11]), .i_ram_crc_evt(ev[12]), .i_fuse_crc_evt(ev[13]), .i_por_flag(por),
        .i_result_valid(rv), .i_result_data(rdat), .o_regmap_crc_en(), .o_ram_crc_en(), .o_fuse_crc_en(),
        .o_master_clock_counter_en(), .o_ext_clock_check_en(), .o_digital_regulator_mon_en(),
        .o_analog_regulator_mon_en(), .o_reference_detect_en(), .o_main_error());
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    // main flags from converter flags, digital any, serial any, power-on
    function automatic logic [23:0] mainx(input logic [7:0] c, input logic d, s, p);
        logic [6:0] m;
        m = {|c[5:1], d, c[0], c[2], c[1], s, p};
        return {16'h0, |m[6:1], m};
    endfunction : mainx
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic rc(input logic [7:0] ad, input logic [23:0] exp);
        host.rd(ad, v);
        chk(v, exp);
    endtask : rc
    task automatic pulse(input logic [13:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 14'h0;
    endtask : pulse
    task automatic results();
        if (failures == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        foreach (OFS[i]) rc(OFS[i], {16'h0, RST[i]});
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            host.wr(8'h28, seed[7:0]);
            rc(8'h28, {16'h0, seed[7:0] & 8'h1E});
            host.wr(8'h29, seed[15:8]);
            rc(8'h29, {16'h0, seed[15:8] & 8'h3F});
            host.wr(8'h2A, seed[23:16]);
            rc(8'h2A, {16'h0, seed[23:16] & 8'h1F});
        end
        foreach (OFS[i]) if (i < 3) host.wr(OFS[i], 8'h00);
        pulse(14'h3FFF);
        rc(8'h2E, 24'h01);
        rc(8'h2F, 24'h00);
        rc(8'h2D, mainx(8'h00, 0, 1, 0));
        host.wr(8'h28, 8'h1E);
        pulse(14'h001F);
        rc(8'h2E, 24'h17);
        cs <= 1'b1;
        pulse(14'h0002);
        rc(8'h2E, 24'h1F);
        host.wr(8'h2E, 8'hFF);
        rc(8'h2E, 24'h08);
        host.wr(8'h29, 8'h3F);
        pulse(14'h07E0);
        rc(8'h2F, 24'h3F);
        rc(8'h2D, mainx(8'h3F, 0, 1, 0));
        host.wr(8'h2A, 8'h1F);
        por <= 1'b1;
        pulse(14'h3800);
        rc(8'h2D, mainx(8'h3F, 1, 1, 1));
        seed = xs(seed);
        rdat <= seed[23:0];
        rv <= 1'b1;
        fork
            rc(8'h2C, seed[23:0]);
            begin
                @(posedge clk);
                rv <= 1'b0;
            end
        join
        host.wr(8'h2C, 8'hA5);
        rc(8'h2C, seed[23:0]);
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        rc(8'h2E, 24'h00);
        rc(8'h2D, mainx(8'h00, 0, 0, 1));
        ce <= 1'b0;
        host.wr(8'h28, 8'h00);
        ce <= 1'b1;
        rc(8'h28, 24'h10);
        results();
    end
endmodule : deb_bank_test
